/* spoc_regs.svh */
`ifndef SPOC_REGS_SVH
`define SPOC_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses on the plain port)
// ----------------------------------------------------------------
`define SPOC_OFF_DRIVE   8'h00
`define SPOC_OFF_ARM     8'h04
`define SPOC_OFF_POS1    8'h08
`define SPOC_OFF_POS2    8'h0c
`define SPOC_OFF_CTRL    8'h10
`define SPOC_OFF_STAT    8'h14
`define SPOC_OFF_STEP    8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SPOC_PAT_LSB     0
`define SPOC_MSK_LSB     8
`define SPOC_MSKGIV_BIT  16
`define SPOC_REL_BIT     17
`define SPOC_DIR1_LSB    18
`define SPOC_HAS2_BIT    20
`define SPOC_DIR2_LSB    21
`define SPOC_RPT_BIT     23
`define SPOC_PERM_BIT    24
`define SPOC_REUSE_BIT   25
`define SPOC_HALT_BIT    0
`define SPOC_REINIT_BIT  1
`define SPOC_CLEAR_BIT   2
`define SPOC_ST_STAGE_LSB 8
`define SPOC_ST_PERM_BIT 10

// ----------------------------------------------------------------
// reset and default values
// ----------------------------------------------------------------
`define SPOC_OUT_IDLE    8'hff
`define SPOC_MASK_ALL    8'hff
`define SPOC_CNT_RST     32'h0000_0000
`define SPOC_CNT_ONE     32'h0000_0001

`endif

/* spoc_pkg.sv */
package spoc_pkg;

	// direction condition of a match point
	typedef enum logic [1:0]
	{
		SPOC_DIR_ANY   = 2'b00,
		SPOC_DIR_PLUS  = 2'b01,
		SPOC_DIR_MINUS = 2'b10
	} spoc_dir_type;

	// deferred function stage, gray along idle -> first -> second
	typedef enum logic [1:0]
	{
		SPOC_IDLE  = 2'b00,
		SPOC_WAIT1 = 2'b01,
		SPOC_WAIT2 = 2'b11
	} spoc_stage_type;

	typedef struct packed
	{
		logic [7:0]   pattern;
		logic [7:0]   mask;
		logic         rel;
		spoc_dir_type dir1;
		logic         has2;
		spoc_dir_type dir2;
		logic         rpt;
		logic         perm;
		logic [31:0]  pos1;
		logic [31:0]  pos2;
	} spoc_cfg_type;

	typedef struct packed
	{
		logic [7:0]     outp;
		logic [31:0]    cnt;
		spoc_stage_type stage;
		logic [31:0]    tgt;
		spoc_cfg_type   cur;
		spoc_cfg_type   last;
		logic [31:0]    pos1;
		logic [31:0]    pos2;
		logic [31:0]    rdata;
		logic           reload;
	} spoc_state_type;

	typedef struct packed
	{
		logic         valid;
		spoc_cfg_type cfg;
	} spoc_keep_type;

endpackage

/* spoc_cross.sv */
module spoc_cross
(
	input  logic [31:0]           prev_cnt,
	input  logic [31:0]           new_cnt,
	input  logic [31:0]           target,
	input  spoc_pkg::spoc_dir_type dir,
	output logic                  hit
);
	import spoc_pkg::*;

	// arrival only counts on a change of the counter, judged from the transition alone
	always_comb
	begin
		hit = 1'b0;
		if ((new_cnt == target) && (prev_cnt != target))
		begin
			unique case (dir)
				SPOC_DIR_PLUS:  hit = $signed(prev_cnt) < $signed(target);
				SPOC_DIR_MINUS: hit = $signed(prev_cnt) > $signed(target);
				SPOC_DIR_ANY:   hit = 1'b1;
				default:        hit = 1'b1; // unused code treated as either direction
			endcase
		end
	end
endmodule

/* spoc_output_ctrl.sv */
// What this block does
// - eight outputs held as one byte
// - immediate and phase drives act at once
// - mask one takes pattern, zero keeps
// - missing mask means all ones
// - deferred pattern applies only at target
// - absolute kind uses position as target
// - relative kind adds counter at arm
// - plus from below, minus from above
// - second point drives complement, ends pulse
// - relative second target offsets first match
// - direction judged from counter transition only
// - empty arm repeats last arm parameters
// - repeat mode rearms until halt
// - repeat relative adds to current counter
// - reset clears arm unless permanent
// - permanent reloads; non-permanent arm cancels
// - earlier immediate change is deferred base
// - later immediate change starts from result
// - reset forces outputs ff, counter zero
`include "spoc_regs.svh"

module spoc_output_ctrl
(
	input  logic        clk,
	input  logic        nrst,
	input  logic        nrst_keep,
	input  logic [7:0]  addr,
	input  logic [31:0] wdata,
	input  logic        wr_stb,
	input  logic        rd_stb,
	output logic [31:0] rdata,
	input  logic        phase_drive_stb,
	input  logic [7:0]  phase_pattern,
	input  logic [7:0]  phase_mask,
	input  logic        phase_mask_given,
	input  logic        step_up,
	input  logic        step_dn,
	output logic [7:0]  logic_out,
	output logic [31:0] step_total
);
	import spoc_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	spoc_state_type s_reg;
	spoc_state_type s_next;
	spoc_keep_type  k_reg;
	spoc_keep_type  k_next;
	logic [31:0]    cnt_next;
	logic           hit;
	logic           fire;
	spoc_dir_type   dir_sel;
	logic           wr_drive;
	logic           wr_arm;
	logic           wr_ctrl;
	logic           do_halt;
	logic           do_reinit;
	logic           do_clear;
	spoc_cfg_type   arm_cfg;

	// masked merge of a new pattern into the old byte
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] pat, input logic [7:0] msk);
		merge = (pat & msk) | (old & ~msk);
	endfunction

	// first target for a configuration, base is the counter at load time
	function automatic logic [31:0] first_tgt(input spoc_cfg_type cfg, input logic [31:0] base);
		first_tgt = cfg.rel ? (cfg.pos1 + base) : cfg.pos1;
	endfunction

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	assign wr_drive  = wr_stb && (addr == `SPOC_OFF_DRIVE);
	assign wr_arm    = wr_stb && (addr == `SPOC_OFF_ARM);
	assign wr_ctrl   = wr_stb && (addr == `SPOC_OFF_CTRL);
	assign do_halt   = wr_ctrl && wdata[`SPOC_HALT_BIT];
	assign do_reinit = wr_ctrl && wdata[`SPOC_REINIT_BIT];
	assign do_clear  = wr_ctrl && wdata[`SPOC_CLEAR_BIT];

	// arm parameters: an empty arm reuses the last executed set
	always_comb
	begin
		arm_cfg         = s_reg.last;
		if (!wdata[`SPOC_REUSE_BIT])
		begin
			arm_cfg.pattern = wdata[`SPOC_PAT_LSB +: 8];
			arm_cfg.mask    = wdata[`SPOC_MSKGIV_BIT] ? wdata[`SPOC_MSK_LSB +: 8] : `SPOC_MASK_ALL;
			arm_cfg.rel     = wdata[`SPOC_REL_BIT];
			arm_cfg.dir1    = spoc_dir_type'(wdata[`SPOC_DIR1_LSB +: 2]);
			arm_cfg.has2    = wdata[`SPOC_HAS2_BIT];
			arm_cfg.dir2    = spoc_dir_type'(wdata[`SPOC_DIR2_LSB +: 2]);
			arm_cfg.rpt     = wdata[`SPOC_RPT_BIT];
			arm_cfg.perm    = wdata[`SPOC_PERM_BIT];
			arm_cfg.pos1    = s_reg.pos1;
			arm_cfg.pos2    = s_reg.pos2;
		end
	end

	// ----------------------------------------------------------------
	// step counter and match detection
	// ----------------------------------------------------------------
	// next counter value; simultaneous up and down cancel
	always_comb
	begin
		if (do_reinit || do_clear)
			cnt_next = `SPOC_CNT_RST;
		else if (step_up && !step_dn)
			cnt_next = s_reg.cnt + `SPOC_CNT_ONE;
		else if (step_dn && !step_up)
			cnt_next = s_reg.cnt - `SPOC_CNT_ONE;
		else
			cnt_next = s_reg.cnt;
	end

	assign dir_sel = (s_reg.stage == SPOC_WAIT2) ? s_reg.cur.dir2 : s_reg.cur.dir1;

	// old and new counter seen together, so a crossing is caught on the update itself
	spoc_cross u_cross
	(
		.prev_cnt (s_reg.cnt),
		.new_cnt  (cnt_next),
		.target   (s_reg.tgt),
		.dir      (dir_sel),
		.hit      (hit)
	);

	assign fire = hit && (s_reg.stage != SPOC_IDLE);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		s_next        = s_reg;
		s_next.rdata  = 32'h0000_0000;
		s_next.reload = 1'b0;
		s_next.cnt    = cnt_next;

		// staging of match positions
		if (wr_stb && (addr == `SPOC_OFF_POS1))
			s_next.pos1 = wdata;
		if (wr_stb && (addr == `SPOC_OFF_POS2))
			s_next.pos2 = wdata;

		// immediate changes first, so the deferred update builds on them
		if (wr_drive)
			s_next.outp = merge(s_next.outp, wdata[`SPOC_PAT_LSB +: 8],
				wdata[`SPOC_MSKGIV_BIT] ? wdata[`SPOC_MSK_LSB +: 8] : `SPOC_MASK_ALL);
		if (phase_drive_stb)
			s_next.outp = merge(s_next.outp, phase_pattern,
				phase_mask_given ? phase_mask : `SPOC_MASK_ALL);

		// deferred match handling
		if (fire)
		begin
			unique case (s_reg.stage)
				SPOC_WAIT1:
				begin
					s_next.outp = merge(s_next.outp, s_reg.cur.pattern, s_reg.cur.mask);
					if (s_reg.cur.has2)
					begin
						s_next.stage = SPOC_WAIT2;
						s_next.tgt   = s_reg.cur.rel ? (s_reg.cur.pos2 + cnt_next) : s_reg.cur.pos2;
					end
					else if (s_reg.cur.rpt)
						s_next.tgt   = first_tgt(s_reg.cur, cnt_next);
					else
						s_next.stage = SPOC_IDLE;
				end
				SPOC_WAIT2:
				begin
					s_next.outp = merge(s_next.outp, ~s_reg.cur.pattern, s_reg.cur.mask);
					if (s_reg.cur.rpt)
					begin
						s_next.stage = SPOC_WAIT1;
						s_next.tgt   = first_tgt(s_reg.cur, cnt_next);
					end
					else
						s_next.stage = SPOC_IDLE;
				end
				default:
					s_next.stage = SPOC_IDLE;
			endcase
		end

		// an arm overrides the stage and target of a match in the same cycle; the match still drives its outputs
		if (wr_arm)
		begin
			s_next.cur   = arm_cfg;
			s_next.last  = arm_cfg;
			s_next.stage = SPOC_WAIT1;
			s_next.tgt   = first_tgt(arm_cfg, s_reg.cnt);
		end

		if (do_halt)
			s_next.stage = SPOC_IDLE;

		// soft reinit behaves as a reset; only a permanent function survives
		if (do_reinit || s_reg.reload)
		begin
			s_next.stage = SPOC_IDLE;
			if (do_reinit)
				s_next.outp = `SPOC_OUT_IDLE;
			if (k_reg.valid)
			begin
				s_next.cur   = k_reg.cfg;
				s_next.last  = k_reg.cfg;
				s_next.stage = SPOC_WAIT1;
				s_next.tgt   = first_tgt(k_reg.cfg, cnt_next);
			end
		end

		// register read, data valid in the next cycle only
		if (rd_stb)
		begin
			unique case (addr)
				`SPOC_OFF_DRIVE: s_next.rdata = {24'h00_0000, s_reg.outp};
				`SPOC_OFF_POS1:  s_next.rdata = s_reg.pos1;
				`SPOC_OFF_POS2:  s_next.rdata = s_reg.pos2;
				`SPOC_OFF_STAT:  s_next.rdata = {21'h00_0000, k_reg.valid, s_reg.stage, s_reg.outp};
				`SPOC_OFF_STEP:  s_next.rdata = s_reg.cnt;
				default:         s_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	// retained store: only a non-permanent arm clears it
	always_comb
	begin
		k_next = k_reg;
		if (wr_arm)
		begin
			k_next.valid = arm_cfg.perm;
			k_next.cfg   = arm_cfg;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// module state; reload is set so a permanent function returns after release
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_reg        <= '0;
			s_reg.outp   <= `SPOC_OUT_IDLE;
			s_reg.cnt    <= `SPOC_CNT_RST;
			s_reg.stage  <= SPOC_IDLE;
			s_reg.reload <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	// retained store stands on its own reset so the module reset leaves it alone
	always_ff @(posedge clk or negedge nrst_keep)
	begin
		if (!nrst_keep)
			k_reg <= '0;
		else
			k_reg <= k_next;
	end

	assign logic_out  = s_reg.outp;
	assign step_total = s_reg.cnt;
	assign rdata      = s_reg.rdata;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic calm;
	assign calm = !wr_drive && !phase_drive_stb && !do_reinit && !fire;

	// an arm in the cycle of a permanent reload is overridden by it, so those cycles are left out
	sequence arm_abs_seq;
		wr_arm && !wdata[`SPOC_REUSE_BIT] && !wdata[`SPOC_REL_BIT] && !s_reg.reload;
	endsequence

	sequence arm_rel_seq;
		wr_arm && !wdata[`SPOC_REUSE_BIT] && wdata[`SPOC_REL_BIT] && !s_reg.reload;
	endsequence

	// a match with no arm, halt or reset acting in the same cycle
	sequence lone_match_seq;
		fire && !wr_arm && !do_halt && !do_reinit && !s_reg.reload;
	endsequence

	chk_reinit_idle_out: assert property (@(posedge clk) disable iff (!nrst)
		do_reinit |=> (logic_out == `SPOC_OUT_IDLE) && (step_total == `SPOC_CNT_RST))
		else $error("reinit did not restore idle outputs and zero count");

	chk_drive_no_mask: assert property (@(posedge clk) disable iff (!nrst)
		wr_drive && !wdata[`SPOC_MSKGIV_BIT] && !phase_drive_stb && !fire && !do_reinit
		|=> logic_out == $past(wdata[`SPOC_PAT_LSB +: 8]))
		else $error("unmasked drive did not set all outputs");

	chk_drive_masked: assert property (@(posedge clk) disable iff (!nrst)
		wr_drive && wdata[`SPOC_MSKGIV_BIT] && !phase_drive_stb && !fire && !do_reinit
		|=> ((logic_out ^ $past(logic_out)) & ~$past(wdata[`SPOC_MSK_LSB +: 8])) == 8'h00)
		else $error("masked drive changed an unmasked output");

	chk_arm_no_change: assert property (@(posedge clk) disable iff (!nrst)
		wr_arm && calm |=> $stable(logic_out))
		else $error("arm changed outputs at once");

	chk_abs_target_load: assert property (@(posedge clk) disable iff (!nrst)
		arm_abs_seq |=> (s_reg.tgt == $past(s_reg.pos1)) && (s_reg.stage == SPOC_WAIT1))
		else $error("absolute target not loaded from position");

	chk_rel_target_load: assert property (@(posedge clk) disable iff (!nrst)
		arm_rel_seq |=> s_reg.tgt == $past(s_reg.pos1) + $past(s_reg.cnt))
		else $error("relative target not offset by counter");

	chk_plus_from_below: assert property (@(posedge clk) disable iff (!nrst)
		fire && (dir_sel == SPOC_DIR_PLUS)
		|=> (step_total == $past(s_reg.tgt)) && ($signed($past(s_reg.cnt)) < $signed(step_total)))
		else $error("plus match fired from above");

	chk_minus_from_above: assert property (@(posedge clk) disable iff (!nrst)
		fire && (dir_sel == SPOC_DIR_MINUS)
		|=> (step_total == $past(s_reg.tgt)) && ($signed($past(s_reg.cnt)) > $signed(step_total)))
		else $error("minus match fired from below");

	chk_second_target: assert property (@(posedge clk) disable iff (!nrst)
		lone_match_seq ##0 ((s_reg.stage == SPOC_WAIT1) && s_reg.cur.has2)
		|=> (s_reg.stage == SPOC_WAIT2)
			&& (s_reg.tgt == $past(s_reg.cur.pos2) + ($past(s_reg.cur.rel) ? step_total : `SPOC_CNT_RST)))
		else $error("second target not set from first match");

	chk_repeat_rearm: assert property (@(posedge clk) disable iff (!nrst)
		lone_match_seq ##0 (s_reg.cur.rpt && ((s_reg.stage == SPOC_WAIT2) || !s_reg.cur.has2))
		|=> (s_reg.stage == SPOC_WAIT1)
			&& (s_reg.tgt == $past(s_reg.cur.pos1) + ($past(s_reg.cur.rel) ? step_total : `SPOC_CNT_RST)))
		else $error("repeat did not rearm from the match position");

	chk_keep_reload: assert property (@(posedge clk) disable iff (!nrst)
		do_reinit && k_reg.valid |=> s_reg.stage == SPOC_WAIT1)
		else $error("permanent function not reloaded by reinit");

	chk_pulse_complement: assert property (@(posedge clk) disable iff (!nrst)
		fire && (s_reg.stage == SPOC_WAIT2) && !wr_drive && !phase_drive_stb && !wr_arm && !do_reinit
		|=> ((logic_out ^ ~$past(s_reg.cur.pattern)) & $past(s_reg.cur.mask)) == 8'h00)
		else $error("second match did not drive complement");

	chk_halt_disarm: assert property (@(posedge clk) disable iff (!nrst)
		do_halt && !do_reinit && !s_reg.reload |=> s_reg.stage == SPOC_IDLE)
		else $error("halt left the deferred function armed");
endmodule

/* spoc_far_model.sv */
// step feed standing in for the motor sequencer that moves the counter
module spoc_far_model
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       move_go,
	input  wire logic       move_up,
	input  wire logic       slow,
	input  wire logic [7:0] move_len,
	output logic            step_up,
	output logic            step_dn,
	output logic            busy
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] rem_reg;
	logic       up_reg;
	logic       tick_reg;

	// busy covers the last pulse too, so the counter has settled once it drops
	assign busy = (rem_reg != 8'h00) | step_up | step_dn;

	// one step per cycle, or every other cycle when slow
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rem_reg  <= 8'h00;
			up_reg   <= 1'b0;
			tick_reg <= 1'b0;
			step_up  <= 1'b0;
			step_dn  <= 1'b0;
		end
		else
		begin
			tick_reg <= ~tick_reg;
			step_up  <= 1'b0;
			step_dn  <= 1'b0;
			if (move_go)
			begin
				rem_reg <= move_len;
				up_reg  <= move_up;
			end
			else if (rem_reg != 8'h00 && (!slow || tick_reg))
			begin
				rem_reg <= rem_reg - 8'h01;
				step_up <= up_reg;
				step_dn <= ~up_reg;
			end
		end
	end
endmodule

/* step_position_output_control_test.sv */
`include "spoc_regs.svh"
module step_position_output_control_test import spoc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk, nrst, nrst_keep, wr_stb, rd_stb, ph_stb, ph_given;
	logic        go, up, slow, step_up, step_dn, busy;
	logic [7:0]  addr, ph_pat, ph_msk, len, logic_out;
	logic [31:0] wdata, rdata, step_total;
	int          fail_count, compares, cycles, cnt;

	spoc_output_ctrl i_dut
	(
		.clk(clk), .nrst(nrst), .nrst_keep(nrst_keep), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .phase_drive_stb(ph_stb),
		.phase_pattern(ph_pat), .phase_mask(ph_msk), .phase_mask_given(ph_given),
		.step_up(step_up), .step_dn(step_dn), .logic_out(logic_out), .step_total(step_total)
	);

	spoc_far_model i_feed
	(
		.clk(clk), .nrst(nrst), .move_go(go), .move_up(up), .slow(slow),
		.move_len(len), .step_up(step_up), .step_dn(step_dn), .busy(busy)
	);

	// ----------------------------------------
	// clock and hang guard
	// ----------------------------------------
	always #12.5 clk = ~clk;

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			complete_run();
		end
	end

	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	// strobes drop one edge before the next task raises them again
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1;
		chk("rdata", rdata, e);
	endtask

	task automatic ph(input logic [7:0] p, input logic [7:0] m, input logic g);
		@(posedge clk);
		ph_stb <= 1'b1;
		ph_pat <= p;
		ph_msk <= m;
		ph_given <= g;
		@(posedge clk);
		ph_stb <= 1'b0;
		#1;
	endtask

	// no command is issued until the feed is idle, so none lands on a match
	task automatic mv(input logic u, input logic [7:0] n);
		@(posedge clk);
		go <= 1'b1;
		up <= u;
		len <= n;
		@(posedge clk);
		go <= 1'b0;
		for (int i = 0; i < 600; i++)
		begin
			@(posedge clk);
			#1;
			if (busy !== 1'b1)
				break;
		end
		cnt += u ? int'(n) : -int'(n);
	endtask

	task automatic do_rst(input logic keep);
		@(posedge clk);
		nrst <= 1'b0;
		nrst_keep <= keep;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		nrst_keep <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		cnt = 0;
	endtask

	function automatic logic [31:0] arm(input logic [7:0] p, input logic [7:0] m, input logic rel,
		input logic [1:0] d1, input logic h2, input logic [1:0] d2, input logic rp, input logic pm);
		return {7'h00, pm, rp, d2, h2, d1, rel, 1'b1, m, p};
	endfunction

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		{clk, nrst, nrst_keep, wr_stb, rd_stb, ph_stb, ph_given, go, up, slow} = '0;
		{addr, ph_pat, ph_msk, len, wdata} = '0;
		do_rst(1'b0);
		chk("logic_out", logic_out, 8'hff);
		chk("step_total", step_total, 0);
		wr(`SPOC_OFF_DRIVE, 32'h5a);
		chk("logic_out", logic_out, 8'h5a);
		rd(`SPOC_OFF_DRIVE, 32'h5a);
		wr(`SPOC_OFF_DRIVE, 32'h1_f000);
		chk("logic_out", logic_out, 8'h0a);
		ph(8'hc3, 8'h0f, 1'b1);
		chk("logic_out", logic_out, 8'h03);
		ph(8'h81, 8'h00, 1'b0);
		chk("logic_out", logic_out, 8'h81);
		// absolute plus match, with a drive before and after it
		wr(`SPOC_OFF_POS1, 4);
		wr(`SPOC_OFF_ARM, arm(8'h00, 8'h0f, 0, SPOC_DIR_PLUS, 0, 0, 0, 0));
		mv(1, 2);
		chk("logic_out", logic_out, 8'h81);
		wr(`SPOC_OFF_DRIVE, 32'hff);
		mv(1, 3);
		chk("logic_out", logic_out, 8'hf0);
		chk("step_total", step_total, cnt);
		wr(`SPOC_OFF_DRIVE, 32'h1_0f0a);
		chk("logic_out", logic_out, 8'hfa);
		rd(`SPOC_OFF_STAT, 32'hfa);
		// passing a plus target from above leaves it armed
		wr(`SPOC_OFF_ARM, arm(8'h00, 8'hff, 0, SPOC_DIR_PLUS, 0, 0, 0, 0));
		mv(0, 3);
		chk("logic_out", logic_out, 8'hfa);
		rd(`SPOC_OFF_STAT, 32'h1fa);
		wr(`SPOC_OFF_POS1, 1);
		wr(`SPOC_OFF_ARM, arm(8'h00, 8'hff, 0, SPOC_DIR_MINUS, 0, 0, 0, 0));
		mv(0, 2);
		chk("logic_out", logic_out, 8'h00);
		// relative pulse with a slow feed
		@(posedge clk);
		slow <= 1'b1;
		wr(`SPOC_OFF_POS1, 2);
		wr(`SPOC_OFF_POS2, 3);
		wr(`SPOC_OFF_ARM, arm(8'h01, 8'h01, 1, SPOC_DIR_ANY, 1, SPOC_DIR_ANY, 0, 0));
		mv(1, 2);
		chk("logic_out", logic_out, 8'h01);
		rd(`SPOC_OFF_STAT, 32'h301);
		mv(1, 3);
		chk("logic_out", logic_out, 8'h00);
		wr(`SPOC_OFF_ARM, 32'h0200_0000);
		mv(1, 2);
		chk("logic_out", logic_out, 8'h01);
		mv(1, 3);
		chk("logic_out", logic_out, 8'h00);
		// repeating relative, then a counter clear breaks the spacing
		@(posedge clk);
		slow <= 1'b0;
		wr(`SPOC_OFF_POS1, 3);
		wr(`SPOC_OFF_ARM, arm(8'h01, 8'h01, 1, SPOC_DIR_ANY, 0, SPOC_DIR_ANY, 1, 0));
		mv(1, 3);
		chk("logic_out", logic_out, 8'h01);
		wr(`SPOC_OFF_DRIVE, 32'h1_0100);
		mv(1, 3);
		chk("logic_out", logic_out, 8'h01);
		wr(`SPOC_OFF_DRIVE, 32'h1_0100);
		wr(`SPOC_OFF_CTRL, 4);
		cnt = 0;
		mv(1, 3);
		chk("logic_out", logic_out, 8'h00);
		rd(`SPOC_OFF_STEP, cnt);
		wr(`SPOC_OFF_CTRL, 1);
		rd(`SPOC_OFF_STAT, 32'h0);
		// permanent function survives soft and hard reset
		wr(`SPOC_OFF_POS1, 2);
		wr(`SPOC_OFF_ARM, arm(8'h55, 8'hff, 0, SPOC_DIR_ANY, 0, SPOC_DIR_ANY, 0, 1));
		rd(`SPOC_OFF_STAT, 32'h500);
		wr(`SPOC_OFF_CTRL, 2);
		cnt = 0;
		chk("logic_out", logic_out, 8'hff);
		rd(`SPOC_OFF_STAT, 32'h5ff);
		mv(1, 2);
		chk("logic_out", logic_out, 8'h55);
		do_rst(1'b1);
		rd(`SPOC_OFF_STAT, 32'h5ff);
		wr(`SPOC_OFF_ARM, arm(8'h00, 8'hff, 0, SPOC_DIR_ANY, 0, SPOC_DIR_ANY, 0, 0));
		rd(`SPOC_OFF_STAT, 32'h1ff);
		wr(`SPOC_OFF_CTRL, 2);
		rd(`SPOC_OFF_STAT, 32'h0ff);
		// plus-only pulse that repeats, then its first point is met from above
		wr(`SPOC_OFF_POS1, 2);
		wr(`SPOC_OFF_POS2, 4);
		wr(`SPOC_OFF_ARM, arm(8'h00, 8'h0f, 0, SPOC_DIR_PLUS, 1, SPOC_DIR_PLUS, 1, 0));
		mv(1, 3);
		chk("logic_out", logic_out, 8'hf0);
		mv(1, 2);
		chk("logic_out", logic_out, 8'hff);
		mv(0, 3);
		rd(`SPOC_OFF_STAT, 32'h1ff);
		// deferred arm without a mask drives all eight outputs
		wr(`SPOC_OFF_ARM, 32'h0);
		mv(1, 1);
		mv(0, 1);
		chk("logic_out", logic_out, 8'h00);
		rd(8'h20, 32'h0);
		complete_run();
	end
endmodule
